/* hw/chan_div_pkg.sv */
// constants for the channel divider register block
package chan_div_pkg;
    localparam logic [8:0] ADDR_DIV0_CYCLE_COUNTS = 9'h190;
    localparam logic [8:0] ADDR_DIV0_CONTROL = 9'h191;
    localparam logic [8:0] ADDR_CHAN0_PATH_CONTROL = 9'h192;
    localparam logic [8:0] ADDR_DIV1_CYCLE_COUNTS = 9'h193;
    localparam logic [8:0] ADDR_DIV1_CONTROL = 9'h194;
    localparam logic [7:0] RST_DIV0_CYCLE_COUNTS = 8'h77;
    localparam logic [7:0] RST_DIV1_CYCLE_COUNTS = 8'h33;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_PATH_CONTROL = 8'h00;
    localparam logic [7:0] PATH_CONTROL_MASK = 8'h07;
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;
    localparam int BIT_BYPASS = 7;
    localparam int BIT_IGNORE_SYNC = 6;
    localparam int BIT_FORCE = 5;
    localparam int BIT_START_HIGH = 4;
    localparam int PHASE_MSB = 3;
    localparam int PHASE_LSB = 0;
    localparam int BIT_POWER_DOWN = 2;
    localparam int BIT_DIRECT = 1;
    localparam int BIT_DCC_DISABLE = 0;
    localparam logic [1:0] MUX_VCO = 2'h2;
    localparam logic [1:0] MUX_EXT = 2'h0;
endpackage

/* hw/output_channel_divider.sv */
// register block and divider logic for output channel group 0
`timescale 1ns/10ps

module output_channel_divider
    import chan_div_pkg::*;
#(
    parameter int CNT_W = 4
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [8:0] i_rd_addr,
    input wire logic i_div_in,
    input wire logic i_vco_clk,
    input wire logic i_ext_clk,
    input wire logic [1:0] i_input_mux,
    input wire logic i_sync_n,
    input wire logic i_invert,
    output logic [7:0] o_rd_data,
    output logic o_group0_output_a,
    output logic o_group0_output_b,
    output logic o_group0_output_c,
    output logic o_group0_power_down,
    output logic o_duty_cycle_correction,
    output logic o_div1_out
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    // bytes are stored whole, path control masked to its low three bits, and fields are sliced where they are used
    logic [7:0] div0_cycle_counts_r;
    logic [7:0] div0_control_r;
    logic [7:0] chan0_path_control_r;
    logic [7:0] div1_cycle_counts_r;
    logic [7:0] div1_control_r;

    // one divider's state: phase down-counter, running counter, level
    // the counter is CNT_W bits; wider count fields would need a wider counter
    typedef enum logic [1:0] {ST_HOLD, ST_PHASE, ST_RUN} div_state_t;
    div_state_t st0_r, st0_nxt, st1_r, st1_nxt;
    logic [CNT_W-1:0] cnt0_r, cnt0_nxt, cnt1_r, cnt1_nxt;
    logic lvl0_r, lvl0_nxt, lvl1_r, lvl1_nxt;

    // sync and clock pins pass three flops; a change counts when stages two and three agree
    logic [2:0] sync_sh_r;
    logic [2:0] vco_sh_r;
    logic [2:0] ext_sh_r;
    logic [2:0] din_sh_r;
    logic sync_n_r;
    logic vco_r;
    logic ext_r;
    logic din_r;
    logic din_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // register writes; unused bits of the path control stay zero
    // a write lands on the edge that samples the strobe; there are no read
    // side effects, so polling never disturbs the dividers
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            div0_cycle_counts_r <= RST_DIV0_CYCLE_COUNTS;
            div0_control_r <= RST_CONTROL;
            chan0_path_control_r <= RST_PATH_CONTROL;
            div1_cycle_counts_r <= RST_DIV1_CYCLE_COUNTS;
            div1_control_r <= RST_CONTROL;
        end
        else if (i_wr_en)
        begin
            case (i_addr)
                ADDR_DIV0_CYCLE_COUNTS: div0_cycle_counts_r <= i_wr_data;
                ADDR_DIV0_CONTROL: div0_control_r <= i_wr_data;
                ADDR_CHAN0_PATH_CONTROL: chan0_path_control_r <= i_wr_data & PATH_CONTROL_MASK;
                ADDR_DIV1_CYCLE_COUNTS: div1_cycle_counts_r <= i_wr_data;
                ADDR_DIV1_CONTROL: div1_control_r <= i_wr_data;
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    // the read data is registered, so it shows the register one cycle late
    // a held read address makes the port a live monitor of that register
    logic [7:0] rd_sel;
    assign rd_sel = (i_rd_addr == ADDR_DIV0_CYCLE_COUNTS) ? div0_cycle_counts_r :
                    (i_rd_addr == ADDR_DIV0_CONTROL) ? div0_control_r :
                    (i_rd_addr == ADDR_CHAN0_PATH_CONTROL) ? chan0_path_control_r :
                    (i_rd_addr == ADDR_DIV1_CYCLE_COUNTS) ? div1_cycle_counts_r :
                    (i_rd_addr == ADDR_DIV1_CONTROL) ? div1_control_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers; first stage feeds only the second
    // the divider input is sampled, not used as a clock: it must stay at or below
    // a quarter of the system clock or edges are lost
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sync_sh_r <= 3'h7;
            vco_sh_r <= 3'h0;
            ext_sh_r <= 3'h0;
            din_sh_r <= 3'h0;
            sync_n_r <= 1'h1;
            vco_r <= 1'h0;
            ext_r <= 1'h0;
            din_r <= 1'h0;
            din_prev_r <= 1'h0;
        end
        else
        begin
            sync_sh_r <= {sync_sh_r[1:0], i_sync_n};
            vco_sh_r <= {vco_sh_r[1:0], i_vco_clk};
            ext_sh_r <= {ext_sh_r[1:0], i_ext_clk};
            din_sh_r <= {din_sh_r[1:0], i_div_in};
            if (sync_sh_r[1] == sync_sh_r[2])
                sync_n_r <= sync_sh_r[2];
            if (vco_sh_r[1] == vco_sh_r[2])
                vco_r <= vco_sh_r[2];
            if (ext_sh_r[1] == ext_sh_r[2])
                ext_r <= ext_sh_r[2];
            if (din_sh_r[1] == din_sh_r[2])
                din_r <= din_sh_r[2];
            din_prev_r <= din_r;
        end
    end

    // one pulse per rising edge of the divider input clock
    // a lost edge only stretches one half period; nothing latches it
    logic tick;
    assign tick = din_r & ~din_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // one divider step, shared by both dividers
    // a held sync wins over a tick, so every release restarts from hold
    typedef struct packed {
        div_state_t st;
        logic [CNT_W-1:0] cnt;
        logic lvl;
    } div_step_t;

    function automatic div_step_t div_step(input div_state_t st, input logic [CNT_W-1:0] cnt,
                                           input logic lvl, input logic [7:0] counts,
                                           input logic [7:0] ctrl, input logic sync_hold,
                                           input logic tk);
        div_step_t r;
        r.st = st;
        r.cnt = cnt;
        r.lvl = lvl;
        if (sync_hold)
        begin
            // held in sync: park at start level, reload phase
            r.st = ST_HOLD;
            r.lvl = ctrl[BIT_START_HIGH];
            r.cnt = ctrl[PHASE_MSB:PHASE_LSB];
        end
        else if (tk)
        begin
            case (st)
                ST_HOLD:
                begin
                    // the first tick after hold only arms the phase count
                    r.st = ST_PHASE;
                    r.cnt = ctrl[PHASE_MSB:PHASE_LSB];
                    r.lvl = ctrl[BIT_START_HIGH];
                end
                ST_PHASE:
                begin
                    // the phase offset is counted down before the first half period
                    if (cnt == '0)
                    begin
                        r.st = ST_RUN;
                        r.cnt = lvl ? counts[HIGH_MSB:HIGH_LSB] : counts[LOW_MSB:LOW_LSB];
                    end
                    else
                        r.cnt = cnt - 1'b1;
                end
                ST_RUN:
                begin
                    // half periods of field+1 ticks each; period is the sum
                    if (cnt == '0)
                    begin
                        r.lvl = ~lvl;
                        r.cnt = lvl ? counts[LOW_MSB:LOW_LSB] : counts[HIGH_MSB:HIGH_LSB];
                    end
                    else
                        r.cnt = cnt - 1'b1;
                end
                default: r.st = ST_HOLD;
            endcase
        end
        return r;
    endfunction

    // sync is held when the pin is low and the divider obeys it
    // sync is a level: while it is held the phase reloads every cycle
    logic hold0, hold1;
    assign hold0 = ~sync_n_r & ~div0_control_r[BIT_IGNORE_SYNC];
    assign hold1 = ~sync_n_r & ~div1_control_r[BIT_IGNORE_SYNC];

    // both dividers step on the same tick so their edges stay aligned
    div_step_t step0, step1;
    assign step0 = div_step(st0_r, cnt0_r, lvl0_r, div0_cycle_counts_r, div0_control_r, hold0,
                            tick);
    assign step1 = div_step(st1_r, cnt1_r, lvl1_r, div1_cycle_counts_r, div1_control_r, hold1,
                            tick);
    assign st0_nxt = step0.st;
    assign cnt0_nxt = step0.cnt;
    assign lvl0_nxt = step0.lvl;
    assign st1_nxt = step1.st;
    assign cnt1_nxt = step1.cnt;
    assign lvl1_nxt = step1.lvl;

    // divider state; bypass holds the counter idle to save power
    // leaving bypass restarts the divider from hold at level low until a tick or held sync loads its start level
    // idle state flops stand in for the divider's own power-down
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || div0_control_r[BIT_BYPASS])
        begin
            st0_r <= ST_HOLD;
            cnt0_r <= '0;
            lvl0_r <= 1'b0;
        end
        else
        begin
            st0_r <= st0_nxt;
            cnt0_r <= cnt0_nxt;
            lvl0_r <= lvl0_nxt;
        end
    end

    // divider 1 runs from the same input clock as divider 0
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || div1_control_r[BIT_BYPASS])
        begin
            st1_r <= ST_HOLD;
            cnt1_r <= '0;
            lvl1_r <= 1'b0;
        end
        else
        begin
            st1_r <= st1_nxt;
            cnt1_r <= cnt1_nxt;
            lvl1_r <= lvl1_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider output: bypass, force, or counted level
    // force only counts when sync is ignored; software keeps that pairing
    function automatic logic div_out(input logic [7:0] ctrl, input logic lvl,
                                     input logic din);
        logic o;
        o = lvl;
        if (ctrl[BIT_BYPASS])
            o = din;
        else if (ctrl[BIT_IGNORE_SYNC] && ctrl[BIT_FORCE])
            o = ctrl[BIT_START_HIGH];
        // ignore-sync with force clear parks the output low; the counter keeps
        // running underneath, so clearing ignore-sync resumes mid-period
        else if (ctrl[BIT_IGNORE_SYNC])
            o = 1'b0;
        return o;
    endfunction

    // divider levels before path select and polarity
    logic div0_level, div1_level;
    assign div0_level = div_out(div0_control_r, lvl0_r, din_r);
    assign div1_level = div_out(div1_control_r, lvl1_r, din_r);

    // with ignore-sync set and force clear the output is forced low unless bypass is set
    logic div0_forced_low;
    assign div0_forced_low = div0_control_r[BIT_IGNORE_SYNC] & ~div0_control_r[BIT_FORCE] &
                             ~div0_control_r[BIT_BYPASS];

    // path select: direct routes only for mux codes 10b and 00b
    // mux codes 01b and 11b keep the divider path even with direct set
    logic direct_on;
    logic path_level;
    assign direct_on = chan0_path_control_r[BIT_DIRECT];
    assign path_level = (direct_on && i_input_mux == MUX_VCO) ? vco_r :
                        (direct_on && i_input_mux == MUX_EXT) ? ext_r :
                        (div0_forced_low ? 1'b0 : div0_level);

    // driver polarity applies in every path, bypass included
    // the invert pin is a static strap, so it is not synchronised
    logic chan_level;
    logic pwr_down;
    assign chan_level = path_level ^ i_invert;
    assign pwr_down = chan0_path_control_r[BIT_POWER_DOWN];

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; power-down parks all three low
    // power-down wins over polarity, so a parked pin never inverts high
    // the three pins share one level but keep their own flops
    // divider 1 is exported as a level only; its channel lies outside
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rd_data <= 8'h00;
            o_group0_output_a <= 1'b0;
            o_group0_output_b <= 1'b0;
            o_group0_output_c <= 1'b0;
            o_group0_power_down <= 1'b0;
            o_duty_cycle_correction <= 1'b1;
            o_div1_out <= 1'b0;
        end
        else
        begin
            o_rd_data <= rd_sel;
            o_group0_output_a <= ~pwr_down & chan_level;
            o_group0_output_b <= ~pwr_down & chan_level;
            o_group0_output_c <= ~pwr_down & chan_level;
            o_group0_power_down <= pwr_down;
            o_duty_cycle_correction <= ~chan0_path_control_r[BIT_DCC_DISABLE];
            o_div1_out <= div1_level;
        end
    end

endmodule // output_channel_divider

/* verification/output_channel_divider_assertions.sv */
// port-level checks for the channel divider register block
`timescale 1ns/10ps
module chan_div_assertions
    import chan_div_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [8:0] i_rd_addr,
    input wire logic i_invert,
    input wire logic [7:0] o_rd_data,
    input wire logic o_group0_output_a,
    input wire logic o_group0_output_b,
    input wire logic o_group0_output_c,
    input wire logic o_group0_power_down,
    input wire logic o_duty_cycle_correction
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // write to the path register, and a write that is read back two edges later
    sequence wr_path;
        i_wr_en && i_addr == ADDR_CHAN0_PATH_CONTROL;
    endsequence
    sequence wr_readback;
        i_wr_en && i_addr == i_rd_addr && i_addr != ADDR_CHAN0_PATH_CONTROL
            && i_addr >= ADDR_DIV0_CYCLE_COUNTS && i_addr <= ADDR_DIV1_CONTROL
            ##1 !i_wr_en && $stable(i_rd_addr);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_read_after_write: assert property (wr_readback |=> o_rd_data == $past(i_wr_data, 2))
        else $error("read back differs from written byte");
    a_path_upper_zero: assert property (i_rd_addr == ADDR_CHAN0_PATH_CONTROL
        |=> o_rd_data[7:3] == 5'h00)
        else $error("unused path bits read nonzero");
    a_unmapped_zero: assert property ((i_rd_addr < ADDR_DIV0_CYCLE_COUNTS
        || i_rd_addr > ADDR_DIV1_CONTROL) |=> o_rd_data == 8'h00)
        else $error("unmapped read nonzero");
    a_pd_follows_write: assert property (wr_path ##0 i_wr_data[BIT_POWER_DOWN]
        |-> ##[1:3] o_group0_power_down)
        else $error("power-down status late");
    a_pd_outputs_low: assert property (o_group0_power_down && $past(o_group0_power_down)
        && !i_invert |-> !o_group0_output_a)
        else $error("output active while powered down");
    a_dcc_disable: assert property (wr_path ##0 i_wr_data[BIT_DCC_DISABLE]
        |-> ##[1:3] !o_duty_cycle_correction)
        else $error("correction still on");
    a_dcc_enable: assert property (wr_path ##0 !i_wr_data[BIT_DCC_DISABLE]
        |-> ##[1:3] o_duty_cycle_correction)
        else $error("correction still off");
    a_three_equal: assert property (o_group0_output_a == o_group0_output_b
        && o_group0_output_b == o_group0_output_c)
        else $error("channel outputs differ");
    a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=> !o_group0_output_a
        && !o_group0_power_down && o_duty_cycle_correction)
        else $error("outputs wrong after reset");
endmodule // chan_div_assertions

/* verification/testbench.sv */
// self-checking bench for the output channel divider
`timescale 1ns/10ps
module testbench;
    import chan_div_pkg::*;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr_en = 1'b0, i_div_in = 1'b0;
    logic [8:0] i_addr = 9'h000, i_rd_addr = 9'h000;
    logic [7:0] i_wr_data = 8'h00, o_rd_data;
    logic i_vco_clk = 1'b0, i_ext_clk = 1'b0, i_sync_n = 1'b1, i_invert = 1'b0;
    logic [1:0] i_input_mux = 2'h1;
    logic o_a, o_b, o_c, o_pd, o_dcc, o_div1_out, probe_sel = 1'b0;
    logic [2:0] dcnt = 3'h0;
    int miscompares = 0, num_checks = 0, cycles = 0, n;
    wire probe = probe_sel ? o_div1_out : o_a;
    output_channel_divider uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .i_div_in(i_div_in),
        .i_vco_clk(i_vco_clk), .i_ext_clk(i_ext_clk), .i_input_mux(i_input_mux),
        .i_sync_n(i_sync_n), .i_invert(i_invert), .o_rd_data(o_rd_data),
        .o_group0_output_a(o_a), .o_group0_output_b(o_b), .o_group0_output_c(o_c),
        .o_group0_power_down(o_pd), .o_duty_cycle_correction(o_dcc), .o_div1_out(o_div1_out));
    ////////////////////////////////////////////////////////////////////////////////
    // clock; divider input is 16 clocks a period, slow enough for the sampler
    initial forever #5 i_clk = ~i_clk;
    always @(negedge i_clk)
    begin
        dcnt <= dcnt + 3'h1;
        if (dcnt == 3'h7)
            i_div_in <= ~i_div_in;
    end
    // hang guard: a stuck span or wait ends the run as a failure
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task bchk(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask
    // one-cycle write strobe, then let the synchronisers settle
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wr_data = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        repeat (10) @(negedge i_clk);
    endtask
    task rdchk(input logic [8:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_rd_addr = a;
        @(negedge i_clk);
        check(o_rd_data, exp);
    endtask
    // length in clocks of the next whole stretch at level lvl on the probe
    task span(input logic lvl, output int len);
        int g;
        g = 0;
        len = 0;
        while (probe !== !lvl && g < 800)
        begin
            @(negedge i_clk);
            g++;
        end
        while (probe !== lvl && g < 1600)
        begin
            @(negedge i_clk);
            g++;
        end
        while (probe === lvl && len < 800)
        begin
            @(negedge i_clk);
            len++;
        end
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_sys_rst = 1'b0;
        rdchk(ADDR_DIV0_CYCLE_COUNTS, 8'h77);
        rdchk(ADDR_CHAN0_PATH_CONTROL, 8'h00);
        rdchk(9'h195, 8'h00);
        rdchk(ADDR_DIV1_CYCLE_COUNTS, 8'h33);
        rdchk(ADDR_DIV1_CONTROL, 8'h00);
        rdchk(ADDR_DIV0_CONTROL, 8'h00);
        wr(ADDR_DIV0_CONTROL, 8'h0A);
        rdchk(ADDR_DIV0_CONTROL, 8'h0A);
        wr(ADDR_DIV0_CONTROL, 8'h00);
        $display("test registers done");
        probe_sel = 1'b1;
        span(1'b1, n);
        check(n[7:0], 8'h40);
        probe_sel = 1'b0;
        wr(ADDR_DIV0_CYCLE_COUNTS, 8'h21);
        span(1'b1, n);
        span(1'b0, n);
        check(n[7:0], 8'h30);
        span(1'b1, n);
        check(n[7:0], 8'h20);
        $display("test counts done");
        wr(ADDR_DIV0_CONTROL, 8'h70);
        bchk(o_a, 1'b1);
        wr(ADDR_DIV0_CONTROL, 8'h60);
        bchk(o_a, 1'b0);
        i_invert = 1'b1;
        repeat (4) @(negedge i_clk);
        bchk(o_a, 1'b1);
        i_invert = 1'b0;
        wr(ADDR_DIV0_CONTROL, 8'hF0);
        span(1'b1, n);
        check(n[7:0], 8'h08);
        $display("test force done");
        // held sync parks at start-high; ignore-sync with force clear drives low
        i_sync_n = 1'b0;
        wr(ADDR_DIV0_CONTROL, 8'h10);
        repeat (100) @(negedge i_clk);
        bchk(o_a, 1'b1);
        wr(ADDR_DIV0_CONTROL, 8'h50);
        bchk(o_a, 1'b0);
        wr(ADDR_DIV0_CONTROL, 8'h10);
        repeat (100) @(negedge i_clk);
        bchk(o_a, 1'b1);
        i_sync_n = 1'b1;
        span(1'b1, n);
        check(n[7:0], 8'h20);
        $display("test sync done");
        wr(ADDR_DIV0_CONTROL, 8'h60);
        i_vco_clk = 1'b1;
        i_input_mux = 2'h2;
        wr(ADDR_CHAN0_PATH_CONTROL, 8'h02);
        bchk(o_a, 1'b1);
        i_input_mux = 2'h0;
        repeat (10) @(negedge i_clk);
        bchk(o_a, 1'b0);
        i_ext_clk = 1'b1;
        repeat (10) @(negedge i_clk);
        bchk(o_a, 1'b1);
        i_input_mux = 2'h1;
        repeat (10) @(negedge i_clk);
        bchk(o_a, 1'b0);
        // direct vco path would drive high, so power-down must pull it low
        i_input_mux = 2'h2;
        wr(ADDR_CHAN0_PATH_CONTROL, 8'hFF);
        rdchk(ADDR_CHAN0_PATH_CONTROL, 8'h07);
        bchk(o_pd, 1'b1);
        bchk(o_a, 1'b0);
        bchk(o_dcc, 1'b0);
        wr(ADDR_CHAN0_PATH_CONTROL, 8'h00);
        bchk(o_dcc, 1'b1);
        $display("test path done");
        finish_test();
    end
endmodule // testbench

bind output_channel_divider chan_div_assertions u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
    .i_invert(i_invert), .o_rd_data(o_rd_data), .o_group0_output_a(o_group0_output_a),
    .o_group0_output_b(o_group0_output_b), .o_group0_output_c(o_group0_output_c),
    .o_group0_power_down(o_group0_power_down),
    .o_duty_cycle_correction(o_duty_cycle_correction));
